// *** dv/dsdma_cpu_model.sv ***
/*
  CPU core model: issues one load or store at a time on the access port.
  Assumes it is called just after a rising clock edge.
*/
`timescale 1ns/10ps
module dsdma_cpu_model
  import dsdma_pkg::*;
(
  input wire logic clk,
  output logic acc_req,
  output logic acc_we,
  output dsdma_mode_e acc_mode,
  output dsdma_ptr_e acc_ptr,
  output logic [5:0] acc_disp,
  output logic acc_io_short,
  output logic [15:0] acc_addr,
  output logic [7:0] acc_wdata,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_fault,
  input wire logic cpu_stall
);
  initial
  begin
    acc_req = 1'b0;
    acc_we = 1'b0;
    acc_mode = M_DIRECT;
    acc_ptr = PTR_X;
    acc_disp = 6'h00;
    acc_io_short = 1'b0;
    acc_addr = 16'h0000;
    acc_wdata = 8'h00;
  end
  // Holds the request until the take edge; cyc stays 0 on a hang
  task automatic access(input logic we, input dsdma_mode_e m, input dsdma_ptr_e p,
    input logic [5:0] d, input logic sh, input logic [15:0] a, input logic [7:0] wd,
    output logic [7:0] rd, output int cyc, output int stl, output logic flt);
    int n;
    cyc = 0;
    stl = 0;
    rd = 8'h00;
    flt = 1'b0;
    acc_we = we;
    acc_mode = m;
    acc_ptr = p;
    acc_disp = d;
    acc_io_short = sh;
    acc_addr = a;
    acc_wdata = wd;
    acc_req = 1'b1;
    n = 0;
    while (acc_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    acc_req = 1'b0;
    // Address, data and displacement lines invert on release so stale values are never mistaken for live ones
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
    acc_disp = ~acc_disp;
    for (n = 1; n < 200; n++)
    begin
      if (cpu_stall === 1'b1) stl++;
      if (acc_done === 1'b1)
      begin
        cyc = n;
        rd = acc_rdata;
        flt = acc_fault;
        break;
      end
      @(posedge clk);
      #1;
    end
  endtask
endmodule

// *** dv/dsdma_top_tb.sv ***
/*
  Self-checking bench for the data space decoder.
  Assumes the CPU model drives the access port; EEPROM times are shortened.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module dsdma_top_tb;
  import dsdma_pkg::*;
  logic clk, rst, acc_req, acc_we, acc_io_short, acc_ready, acc_done, acc_fault, cpu_stall;
  dsdma_mode_e acc_mode;
  dsdma_ptr_e acc_ptr;
  logic [5:0] acc_disp;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, rd;
  logic pc_step, pc_load, flt;
  logic [12:0] pc_target, pc;
  int failures = 0, n_tests = 0, cyc, stl;
  logic [15:0] adr_tab [8] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F,
    16'h0060, 16'h00FF, 16'h0100, 16'h04FF};
  dsdma_top #(.VARIANT(2), .EE_ATOMIC_CYC(20), .EE_SPLIT_CYC(10)) uut (.clk(clk),
    .rst(rst), .acc_req(acc_req), .acc_we(acc_we), .acc_mode(acc_mode),
    .acc_ptr(acc_ptr), .acc_disp(acc_disp), .acc_io_short(acc_io_short),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_fault(acc_fault),
    .cpu_stall(cpu_stall), .pc_step(pc_step), .pc_load(pc_load),
    .pc_target(pc_target), .program_counter(pc));
  dsdma_cpu_model cpu (.clk(clk), .acc_req(acc_req), .acc_we(acc_we),
    .acc_mode(acc_mode), .acc_ptr(acc_ptr), .acc_disp(acc_disp),
    .acc_io_short(acc_io_short), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .acc_fault(acc_fault), .cpu_stall(cpu_stall));
  // ****************************************
  // Clock and helpers
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One idle edge after each access keeps acc_req from toggling twice in a step
  task automatic acc(input logic we, input dsdma_mode_e m, input dsdma_ptr_e p,
    input logic [5:0] d, input logic sh, input logic [15:0] a, input logic [7:0] wd);
    cpu.access(we, m, p, d, sh, a, wd, rd, cyc, stl, flt);
    if (cyc == 0)
    begin
      failures++;
      $display("ERROR %0t access hang", $time);
      results();
    end
    @(posedge clk);
    #1;
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, M_DIRECT, PTR_X, 6'h00, 1'b0, a, d);
  endtask
  task automatic r(input logic [15:0] a);
    acc(1'b0, M_DIRECT, PTR_X, 6'h00, 1'b0, a, 8'h00);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regions();
    for (int i = 0; i < 8; i++) w(adr_tab[i], 8'hA0 + 8'(i));
    for (int i = 0; i < 8; i++)
    begin
      r(adr_tab[i]);
      `CHK(rd, 8'hA0 + 8'(i))
      `CHK(cyc, (i < 6) ? 1 : 2)
      `CHK(flt, 1'b0)
    end
    w(16'h0500, 8'h5A);
    `CHK(flt, 1'b1)
    r(16'h0100);
    `CHK(rd, 8'hA6)
    r(16'h0500);
    `CHK(rd, 8'h00)
    acc(1'b1, M_DIRECT, PTR_X, 6'h00, 1'b1, 16'h00FF, 8'h3C);
    r(16'h00FF);
    `CHK(rd, 8'hA5)
    r(16'h005F);
    `CHK(rd, 8'h3C)
    acc(1'b0, M_DIRECT, PTR_X, 6'h00, 1'b1, 16'h0000, 8'h00);
    `CHK(rd, 8'hA2)
    $display("test regions done");
  endtask
  task automatic t_pointers();
    w(16'h001A, 8'h00);
    w(16'h001B, 8'h01);
    acc(1'b1, M_IND, PTR_X, 6'h00, 1'b0, 16'h0000, 8'h11);
    `CHK(cyc, 2)
    acc(1'b1, M_POSTINC, PTR_X, 6'h00, 1'b0, 16'h0000, 8'h22);
    r(16'h001A);
    `CHK(rd, 8'h01)
    acc(1'b0, M_PREDEC, PTR_X, 6'h00, 1'b0, 16'h0000, 8'h00);
    `CHK(rd, 8'h22)
    w(16'h001C, 8'h00);
    w(16'h001D, 8'h01);
    acc(1'b1, M_DISP, PTR_Y, 6'h3F, 1'b0, 16'h0000, 8'h33);
    r(16'h013F);
    `CHK(rd, 8'h33)
    w(16'h001E, 8'h05);
    w(16'h001F, 8'h00);
    acc(1'b1, M_IND, PTR_Z, 6'h00, 1'b0, 16'h0000, 8'h44);
    r(16'h0005);
    `CHK(rd, 8'h44)
    w(16'h001E, 8'h50);
    acc(1'b1, M_DISP, PTR_Z, 6'h0F, 1'b0, 16'h0000, 8'h55);
    r(16'h005F);
    `CHK(rd, 8'h55)
    w(16'h001E, 8'hF0);
    acc(1'b1, M_PREDEC, PTR_Z, 6'h00, 1'b0, 16'h0000, 8'h66);
    r(16'h00EF);
    `CHK(rd, 8'h66)
    r(16'h001E);
    `CHK(rd, 8'hEF)
    acc(1'b1, M_POSTINC, PTR_Z, 6'h00, 1'b0, 16'h0000, 8'h77);
    r(16'h00EF);
    `CHK(rd, 8'h77)
    r(16'h001E);
    `CHK(rd, 8'hF0)
    $display("test pointers done");
  endtask
  task automatic t_eeprom();
    int k;
    w(16'h0041, 8'h05);
    w(16'h0042, 8'h00);
    w(16'h0040, 8'hC3);
    w(16'h003F, 8'h04);
    w(16'h003F, 8'h02);
    `CHK(cyc, 3)
    `CHK(stl, 2)
    r(16'h003F);
    `CHK(rd[1], 1'b1)
    for (k = 0; k < 40 && rd[1] === 1'b1; k++) r(16'h003F);
    `CHK(rd[1], 1'b0)
    w(16'h0040, 8'h00);
    pc_step = 1'b1;
    w(16'h003F, 8'h01);
    pc_step = 1'b0;
    `CHK(cyc, 5)
    `CHK(pc, 13'h0002)
    `CHK(stl, 4)
    r(16'h0040);
    `CHK(rd, 8'hC3)
    w(16'h0040, 8'h77);
    w(16'h003F, 8'h02);
    r(16'h003F);
    `CHK(rd[1], 1'b0)
    w(16'h003F, 8'h04);
    repeat (6) @(posedge clk);
    #1;
    w(16'h003F, 8'h02);
    r(16'h003F);
    `CHK(rd[1], 1'b0)
    w(16'h003F, 8'h01);
    r(16'h0040);
    `CHK(rd, 8'hC3)
    $display("test eeprom done");
  endtask
  // Master enable, strobe after gap idle edges, busy polled, then the byte read back
  task automatic ee_wr(input logic [7:0] m, input int gap);
    w(16'h003F, 8'h04 | m);
    repeat (gap)
    begin
      @(posedge clk);
      #1;
    end
    w(16'h003F, 8'h02 | m);
    r(16'h003F);
    for (int k = 0; k < 40 && rd[1] === 1'b1; k++) r(16'h003F);
    `CHK(rd[1], 1'b0)
    w(16'h003F, 8'h01);
    r(16'h0040);
  endtask
  // Gap 2 puts the strobe on the last edge of the enable window, gap 3 just past it
  task automatic t_ee_modes();
    w(16'h0040, 8'h0F);
    ee_wr(8'h10, 0);
    `CHK(rd, 8'hFF)
    w(16'h0040, 8'h3C);
    ee_wr(8'h20, 2);
    `CHK(rd, 8'h3C)
    w(16'h0040, 8'h0F);
    ee_wr(8'h20, 0);
    `CHK(rd, 8'h0C)
    w(16'h0040, 8'h55);
    ee_wr(8'h00, 3);
    `CHK(rd, 8'h0C)
    $display("test eeprom modes done");
  endtask
  task automatic t_pc();
    pc_target = 13'h1FFF;
    pc_load = 1'b1;
    @(posedge clk);
    #1;
    pc_load = 1'b0;
    `CHK(pc, 13'h1FFF)
    pc_step = 1'b1;
    @(posedge clk);
    #1;
    `CHK(pc, 13'h0000)
    repeat (3) @(posedge clk);
    #1;
    pc_step = 1'b0;
    `CHK(pc, 13'h0003)
    $display("test pc done");
  endtask
  // Reset in mid-run, while a write is still programming
  task automatic t_reset();
    w(16'h003F, 8'h04);
    w(16'h003F, 8'h02);
    r(16'h04FF);
    `CHK(rd, 8'hA7)
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK(acc_rdata, 8'h00)
    `CHK(acc_fault, 1'b0)
    `CHK(pc, 13'h0000)
    `CHK(cpu_stall, 1'b0)
    `CHK(acc_ready, 1'b1)
    r(16'h003F);
    `CHK(rd, 8'h00)
    $display("test reset done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    pc_step = 1'b0;
    pc_load = 1'b0;
    pc_target = 13'h0000;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK(pc, 13'h0000)
    `CHK(acc_ready, 1'b1)
    `CHK(cpu_stall, 1'b0)
    t_regions();
    t_pointers();
    t_eeprom();
    t_ee_modes();
    t_pc();
    t_reset();
    results();
  end
endmodule

// *** hw/dsdma_ee_if.sv ***
/*
  Register port between the decoder and the EEPROM access unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface dsdma_ee_if;
  logic wr;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_go;
  logic wr_go;
  modport host (output wr, output sel, output wdata, input rdata, input rd_go, input wr_go);
  modport ee (input wr, input sel, input wdata, output rdata, output rd_go, output wr_go);
endinterface

// *** hw/dsdma_eeprom.sv ***
/*
  EEPROM byte store with its control, data and address registers.
  Assumes writes arrive from the decoder in the cycle the access is taken.
*/
`timescale 1ns/10ps
module dsdma_eeprom
  import dsdma_pkg::*;
#(
  parameter int EE_N = 512,
  parameter int ATOM_CYC = ATOMIC_CYC,
  parameter int SPL_CYC = SPLIT_CYC,
  parameter int TW = 16
)(
  input wire logic clk,
  input wire logic rst,
  dsdma_ee_if.ee bus
);
  localparam int EA_W = $clog2(EE_N);
  logic [7:0] mem [EE_N];
  logic [7:0] data_q;
  logic [8:0] adr_q;
  logic [1:0] pm_q;
  logic rie_q;
  logic mwe_q;
  logic [2:0] mwe_cnt_q;
  logic busy_q;
  logic [TW-1:0] tmr_q;
  logic [EA_W-1:0] padr_q;
  logic [7:0] pdat_q;
  logic ctl_wr;
  logic set_mwe;

  assign ctl_wr = bus.wr && bus.sel == SEL_CTL;
  assign set_mwe = ctl_wr && bus.wdata[CTL_MWE];
  assign bus.rd_go = ctl_wr && bus.wdata[CTL_RD] && !busy_q;
  assign bus.wr_go = ctl_wr && bus.wdata[CTL_WSTROBE] && mwe_q && !busy_q;

  always_comb
  begin
    case (bus.sel)
      SEL_CTL: bus.rdata = {2'h0, pm_q, rie_q, mwe_q, busy_q, 1'b0};
      SEL_DATA: bus.rdata = data_q;
      SEL_ADRL: bus.rdata = adr_q[7:0];
      default: bus.rdata = {7'h00, adr_q[8]};
    endcase
  end

  // ****************************************
  // Master write enable window
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end
    else if (set_mwe)
    begin
      mwe_q <= 1'b1;
      mwe_cnt_q <= MWE_WINDOW;
    end
    else if (mwe_q)
    begin
      mwe_cnt_q <= mwe_cnt_q - 3'h1;
      if (mwe_cnt_q == 3'h1)
        mwe_q <= 1'b0;
    end
  end

  // ****************************************
  // Control, address and data registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pm_q <= 2'h0;
      rie_q <= 1'b0;
      adr_q <= 9'h000;
      data_q <= 8'h00;
    end
    else
    begin
      if (ctl_wr)
      begin
        rie_q <= bus.wdata[CTL_RIE];
        // Mode is frozen while a write runs
        if (!busy_q)
          pm_q <= bus.wdata[CTL_PM_LO+1:CTL_PM_LO];
      end
      if (bus.wr && bus.sel == SEL_ADRL)
        adr_q[7:0] <= bus.wdata;
      if (bus.wr && bus.sel == SEL_ADRH)
        adr_q[8] <= (EE_N > 256) && bus.wdata[0];
      if (bus.wr && bus.sel == SEL_DATA)
        data_q <= bus.wdata;
      else if (bus.rd_go)
        data_q <= mem[adr_q[EA_W-1:0]];
    end
  end

  // ****************************************
  // Self timed programming
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      padr_q <= '0;
      pdat_q <= 8'h00;
    end
    else if (bus.wr_go)
    begin
      busy_q <= 1'b1;
      tmr_q <= (pm_q == 2'h0) ? TW'(ATOM_CYC) : TW'(SPL_CYC);
      padr_q <= adr_q[EA_W-1:0];
      pdat_q <= data_q;
    end
    else if (busy_q)
    begin
      tmr_q <= tmr_q - 1'b1;
      if (tmr_q == TW'(1))
        busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (busy_q && tmr_q == TW'(1))
    begin
      case (pm_q)
        2'h1: mem[padr_q] <= 8'hFF;
        2'h2: mem[padr_q] <= mem[padr_q] & pdat_q;
        default: mem[padr_q] <= pdat_q;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_mwe_expires: assert property (mwe_q && mwe_cnt_q == 3'h1 && !set_mwe |=> !mwe_q)
    else $error("master write enable outlived its window");
  a_strobe_gated: assert property (bus.wr_go |-> mwe_q && !busy_q)
    else $error("write started without master enable");
  a_busy_shown: assert property (bus.wr_go |=> busy_q && bus.sel != SEL_CTL || bus.rdata[1])
    else $error("programming not reported as busy");
endmodule

// *** hw/dsdma_pkg.sv ***
/*
  Constants, types and small helpers shared by the data space decoder and its
  EEPROM access unit. Assumes a single 10 MHz CPU clock.
*/
package dsdma_pkg;
  // ****************************************
  // Clock and data space layout
  // ****************************************
  localparam int CLK_NS = 100;
  localparam logic [15:0] REG_TOP = 16'h001F;
  localparam logic [15:0] SIO_BASE = 16'h0020;
  localparam logic [15:0] SIO_TOP = 16'h005F;
  localparam logic [15:0] XIO_TOP = 16'h00FF;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam int REG_CNT = 32;
  localparam int IO_CNT = 224;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  // ****************************************
  // EEPROM access registers, as I/O indices
  // ****************************************
  localparam logic [7:0] IO_EECTL = 8'h1F;
  localparam logic [7:0] IO_EELAST = 8'h22;
  localparam logic [1:0] SEL_CTL = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_ADRL = 2'h2;
  localparam logic [1:0] SEL_ADRH = 2'h3;
  localparam int CTL_RD = 0;
  localparam int CTL_WSTROBE = 1;
  localparam int CTL_MWE = 2;
  localparam int CTL_RIE = 3;
  localparam int CTL_PM_LO = 4;
  localparam logic [2:0] MWE_WINDOW = 3'h4;
  localparam logic [2:0] EE_RD_STALL = 3'h4;
  localparam logic [2:0] EE_WR_STALL = 3'h2;
  localparam int T_ATOMIC_NS = 3400000;
  localparam int T_SPLIT_NS = 1800000;
  localparam int ATOMIC_CYC = (T_ATOMIC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPLIT_CYC = (T_SPLIT_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    M_DIRECT = 3'h0, M_IND = 3'h1, M_DISP = 3'h2, M_PREDEC = 3'h3, M_POSTINC = 3'h4
  } dsdma_mode_e;
  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} dsdma_ptr_e;
  typedef enum logic [4:0] {
    RG_REG = 5'h01, RG_SIO = 5'h02, RG_XIO = 5'h04, RG_SRAM = 5'h08, RG_NONE = 5'h10
  } dsdma_region_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_WAIT = 3'h2, ST_STALL = 3'h4} dsdma_state_e;

  function automatic int sram_bytes(input int v);
    return (v == 0) ? 512 : 1024;
  endfunction
  function automatic int ee_bytes(input int v);
    return (v == 0) ? 256 : 512;
  endfunction
  function automatic int pc_bits(input int v);
    return 11 + v;
  endfunction
endpackage

// *** hw/dsdma_top.sv ***
/*
  Data space decoder: working registers, standard and extended I/O, internal
  SRAM, EEPROM access stalls and the program counter.
  Assumes the CPU core drives the access port from the same clock.
*/
// Behaviour
// - Addresses 0x0000-0x001F hit working registers
// - Addresses 0x0020-0x005F hit standard I/O
// - Addresses 0x0060-0x00FF hit extended I/O
// - Short I/O form cannot reach extended I/O
// - SRAM from 0x0100, size set by variant
// - Direct addressing reaches the whole data space
// - Displacement mode: pointer plus six-bit offset
// - Pre-decrement before, post-increment after access
// - Registers 26 to 31 hold X, Y, Z
// - Every mode reaches every region
// - SRAM access completes in two cycles
// - EEPROM read stalls the CPU four cycles
// - EEPROM write start stalls two cycles
// - EEPROM is separate byte-addressed store
// - EEPROM registers live in I/O space
// - EEPROM self-times writes, shows busy status
// - Program flash is 16-bit words by variant
// - Program counter width matches flash words
// - Strobe within four cycles of master enable
`timescale 1ns/10ps
module dsdma_top
  import dsdma_pkg::*;
#(
  parameter int VARIANT = 2,
  parameter int PC_W = pc_bits(VARIANT),
  parameter int EE_ATOMIC_CYC = ATOMIC_CYC,
  parameter int EE_SPLIT_CYC = SPLIT_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire dsdma_mode_e acc_mode,
  input wire dsdma_ptr_e acc_ptr,
  input wire logic [5:0] acc_disp,
  input wire logic acc_io_short,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  output logic acc_fault,
  output logic cpu_stall,
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_target,
  output logic [PC_W-1:0] program_counter
);
  // ****************************************
  // Sizes fixed by the built variant
  // ****************************************
  localparam int SRAM_N = sram_bytes(VARIANT);
  localparam int SA_W = $clog2(SRAM_N);
  localparam logic [15:0] RAM_END = SRAM_BASE + 16'(SRAM_N - 1);
  localparam int FLASH_WORDS = 1 << PC_W;

  logic [7:0] rf_q [REG_CNT];
  logic [7:0] io_q [IO_CNT];
  logic [7:0] sram_q [SRAM_N];
  dsdma_state_e st_q;
  logic [2:0] cnt_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic fault_q;
  logic [PC_W-1:0] pc_q;
  logic [4:0] plo;
  logic [4:0] phi;
  logic [15:0] ptr;
  logic [15:0] ptr_new;
  logic ptr_upd;
  logic [15:0] eaddr;
  dsdma_region_e rg;
  logic [7:0] io_idx;
  logic [SA_W-1:0] sram_idx;
  logic ee_hit;
  logic take;
  logic [7:0] rd_val;

  dsdma_ee_if eif();

  dsdma_eeprom #(
    .EE_N(ee_bytes(VARIANT)),
    .ATOM_CYC(EE_ATOMIC_CYC),
    .SPL_CYC(EE_SPLIT_CYC),
    .TW(16)
  ) u_ee (
    .clk(clk),
    .rst(rst),
    .bus(eif.ee)
  );

  // ****************************************
  // Effective address
  // ****************************************
  always_comb
  begin
    case (acc_ptr)
      PTR_X: plo = PTR_X_LO;
      PTR_Y: plo = PTR_Y_LO;
      default: plo = PTR_Z_LO;
    endcase
  end

  assign phi = {plo[4:1], 1'b1};
  assign ptr = {rf_q[phi], rf_q[plo]};

  always_comb
  begin
    eaddr = acc_addr;
    ptr_new = ptr;
    ptr_upd = 1'b0;
    if (acc_io_short)
      eaddr = SIO_BASE + {10'h000, acc_addr[5:0]};
    else
    begin
      case (acc_mode)
        M_DIRECT: eaddr = acc_addr;
        M_IND: eaddr = ptr;
        M_DISP: eaddr = ptr + {10'h000, acc_disp};
        M_PREDEC:
        begin
          eaddr = ptr - 16'h0001;
          ptr_new = ptr - 16'h0001;
          ptr_upd = 1'b1;
        end
        M_POSTINC:
        begin
          eaddr = ptr;
          ptr_new = ptr + 16'h0001;
          ptr_upd = 1'b1;
        end
        default: eaddr = acc_addr;
      endcase
    end
  end

  // ****************************************
  // Region decode
  // ****************************************
  // Decode works on the final address only, so every mode lands on every region
  always_comb
  begin
    if (eaddr <= REG_TOP)
      rg = RG_REG;
    else if (eaddr <= SIO_TOP)
      rg = RG_SIO;
    else if (eaddr <= XIO_TOP)
      rg = RG_XIO;
    else if (eaddr <= RAM_END)
      rg = RG_SRAM;
    else
      rg = RG_NONE;
  end

  assign io_idx = eaddr[7:0] - SIO_BASE[7:0];
  assign sram_idx = SA_W'(eaddr - SRAM_BASE);
  assign ee_hit = rg == RG_SIO && io_idx >= IO_EECTL && io_idx <= IO_EELAST;
  assign take = acc_req && st_q == ST_IDLE;

  assign eif.wr = take && acc_we && ee_hit;
  assign eif.sel = 2'(io_idx - IO_EECTL);
  assign eif.wdata = acc_wdata;

  always_comb
  begin
    case (rg)
      RG_REG: rd_val = rf_q[eaddr[4:0]];
      RG_SIO: rd_val = ee_hit ? eif.rdata : io_q[io_idx];
      RG_XIO: rd_val = io_q[io_idx];
      RG_SRAM: rd_val = sram_q[sram_idx];
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // Storage writes
  // ****************************************
  // Pointer update comes last so it wins if the access also hit that pointer
  always_ff @(posedge clk)
  begin
    if (take)
    begin
      if (acc_we && rg == RG_REG)
        rf_q[eaddr[4:0]] <= acc_wdata;
      if (ptr_upd)
      begin
        rf_q[plo] <= ptr_new[7:0];
        rf_q[phi] <= ptr_new[15:8];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (take && acc_we && (rg == RG_SIO || rg == RG_XIO) && !ee_hit)
      io_q[io_idx] <= acc_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (take && acc_we && rg == RG_SRAM)
      sram_q[sram_idx] <= acc_wdata;
  end

  // ****************************************
  // Access sequencing and stalls
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      fault_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (take)
          begin
            rdata_q <= acc_we ? 8'h00 : rd_val;
            fault_q <= rg == RG_NONE;
            if (eif.rd_go)
            begin
              st_q <= ST_STALL;
              cnt_q <= EE_RD_STALL;
            end
            else if (eif.wr_go)
            begin
              st_q <= ST_STALL;
              cnt_q <= EE_WR_STALL;
            end
            else if (rg == RG_SRAM)
              st_q <= ST_WAIT;
            else
              done_q <= 1'b1;
          end
        end
        ST_WAIT:
        begin
          st_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        ST_STALL:
        begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1)
          begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign acc_ready = st_q == ST_IDLE;
  assign acc_done = done_q;
  assign acc_rdata = rdata_q;
  assign acc_fault = fault_q;
  assign cpu_stall = st_q == ST_STALL;

  // ****************************************
  // Program counter
  // ****************************************
  // Wraps at the flash size since the width equals the word address
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= '0;
    else if (pc_load)
      pc_q <= pc_target;
    else if (pc_step && !cpu_stall)
      pc_q <= pc_q + 1'b1;
  end

  assign program_counter = pc_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_region_onehot: assert property (take |-> $onehot(rg) && FLASH_WORDS > 0)
    else $error("region select not one-hot");
  a_low_regs: assert property (take && eaddr <= 16'h001F |-> rg == RG_REG)
    else $error("low addresses missed the register file");
  a_std_io_map: assert property (take && eaddr >= 16'h0020 && eaddr <= 16'h005F
    |-> rg == RG_SIO)
    else $error("standard I/O decode wrong");
  a_ext_io_map: assert property (take && eaddr >= 16'h0060 && eaddr <= 16'h00FF
    |-> rg == RG_XIO)
    else $error("extended I/O decode wrong");
  a_short_io: assert property (take && acc_io_short |-> rg == RG_SIO)
    else $error("short I/O reached beyond standard I/O");
  a_sram_two: assert property (take && rg == RG_SRAM
    |=> st_q == ST_WAIT && !done_q ##1 done_q)
    else $error("SRAM access not two cycles");
  a_ee_rd_stall: assert property (take && eif.rd_go
    |=> cpu_stall [*4] ##1 (!cpu_stall && done_q))
    else $error("EEPROM read stall not four cycles");
  a_ee_wr_stall: assert property (take && eif.wr_go
    |=> cpu_stall [*2] ##1 (!cpu_stall && done_q))
    else $error("EEPROM write stall not two cycles");
  a_post_inc: assert property (take && !acc_io_short && acc_mode == M_POSTINC
    && acc_ptr == PTR_Z && !(acc_we && rg == RG_REG)
    |=> {rf_q[31], rf_q[30]} == $past(ptr) + 16'h0001)
    else $error("Z pointer not incremented");
  a_above_top: assert property (take && rg == RG_NONE |=> fault_q && done_q
    && acc_rdata == 8'h00)
    else $error("access above SRAM not flagged");

  c_sram_access: cover property (take && rg == RG_SRAM ##2 done_q);
  c_ee_read: cover property (take && eif.rd_go ##5 done_q);
  c_ee_write: cover property (take && eif.wr_go ##3 done_q);
  c_predec: cover property (take && acc_mode == M_PREDEC && !acc_io_short);
endmodule
